/* tb/siwc_partner.sv */
`timescale 1ns/1ps
module siwc_partner #(
	parameter int LOCK_WAIT = 1500
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// clock generator
	input wire logic pll_en,
	output logic pll_locked
);
	int cnt;
	// lock after wait
	// the flag drops at the first clock edge that sees the pll switched off, so a stale lock never survives sleep
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn || !pll_en) begin
			cnt <= 0;
			pll_locked <= 1'b0;
		end else if (cnt < LOCK_WAIT) begin
			cnt <= cnt + 1;
		end else begin
			pll_locked <= 1'b1;
		end
	end
endmodule : siwc_partner

/* tb/sleep_idle_wake_control_tb_top.sv */
`timescale 1ns/1ps
module sleep_idle_wake_control_tb_top;
	import siwc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0, hreadyout, hresp, psi = 1'b0, sel = 1'b0, pll_locked;
	logic [2:0] fam = 3'h1;
	logic [4:0] pri = 5'h0;
	siwc_wake_s wake = '0;
	siwc_clk_s ck;
	siwc_osc_e cur;
	int err_count = 0, n_tests = 0, n, lock_cyc;
	integer seed = 32'hab76;

	always #50 hclk = ~hclk;

	siwc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .power_save_instruction(psi), .power_save_sleep_sel(sel),
		.wake_src(wake), .pll_locked(pll_locked), .osc_family_config(fam), .primary_osc_config(pri),
		.clk_ctl(ck), .current_osc_select(cur));

	// lock wait exceeds the start-up timer so the lock stage really holds the clock off
	siwc_partner #(.LOCK_WAIT(1500)) i_partner (.hclk(hclk), .hresetn(hresetn), .pll_en(ck.pll_en),
		.pll_locked(pll_locked));

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
		n_tests++;
		if (tol == 0 ? got !== exp : (got + tol < exp || got > exp + tol)) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic rst(input logic [2:0] f, input logic [4:0] p);
		hresetn <= 1'b0;
		fam <= f;
		pri <= p;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
	endtask : rst

	task automatic enter(input logic s);
		psi <= 1'b1;
		sel <= s;
		@(posedge hclk);
		psi <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask : enter

	// latency counted in edges from the edge that samples the wake bit
	// outputs are looked at on the falling edge, where they have settled
	task automatic wake_up(input int b);
		wake <= siwc_wake_s'(5'h1 << b);
		@(posedge hclk);
		wake <= '0;
		n = 0;
		lock_cyc = 0;
		do begin
			@(negedge hclk);
			n++;
			if (pll_locked === 1'b1 && lock_cyc == 0)
				lock_cyc = n;
		end while (ck.cpu_clk_en !== 1'b1 && n < 5000);
		@(posedge hclk);
	endtask : wake_up

	initial begin
		#3ms;
		err_count++;
		finish_test();
	end

	initial begin
		for (int b = 0; b < 4; b++) begin
			rst(3'(b), 5'($unsigned($random(seed))));
			chk(32'(cur), b);
			ahb(1'b0, CTRL_ADDR, 0);
			chk(rd, 32'(CTRL_RST));
			ahb(1'b1, CTRL_ADDR, 32'hf2);
			ahb(1'b0, CTRL_ADDR, 0);
			chk(rd, 32'hf2);
			ahb(1'b0, 32'h40, 0);
			chk(rd, 0);
			chk(32'(hresp), 0);
			enter(1'b1);
			chk(32'(ck), 32'h02e);
			repeat (2 + ($unsigned($random(seed)) % 8)) @(posedge hclk);
			wake_up(b);
			chk(n, POR_CYC + 1);
			chk(32'(cur), b);
			$display("fast wake %0d done", b);
		end
		wake <= 5'h10;
		@(posedge hclk);
		wake <= '0;
		@(negedge hclk);
		chk(ck.wdt_reset_req, 1);
		@(posedge hclk);
		ahb(1'b1, STAT_ADDR, 32'h1f00);
		// switching on with the rc clock picked, so the pre-sleep source must survive the wake
		ahb(1'b1, CTRL_ADDR, 32'hf5);
		enter(1'b1);
		wake_up(4);
		chk(n, POR_CYC + 1);
		chk(32'(cur), 2);
		ahb(1'b0, STAT_ADDR, 0);
		chk(rd[12:8], 5'h10);
		ahb(1'b1, STAT_ADDR, 32'h1000);
		ahb(1'b0, STAT_ADDR, 0);
		chk(rd[12:8], 0);
		enter(1'b0);
		chk(ck[9:8], 2'b01);
		wake_up(0);
		chk(n, 1);
		$display("watchdog and idle done");
		rst(3'h5, 5'h0);
		ahb(1'b1, CTRL_ADDR, 32'hf2);
		enter(1'b1);
		wake_up(0);
		chk(n, OST_CYC + FULL_CYC + 1);
		chk(32'(cur), 5);
		rst(3'h4, 5'h0);
		ahb(1'b1, CTRL_ADDR, 32'h1f2);
		enter(1'b1);
		wake_up(1);
		chk(n, POR_CYC + 1);
		rst(3'h7, 5'h6);
		chk(32'(cur), 6);
		ahb(1'b1, CTRL_ADDR, 32'hf2);
		enter(1'b1);
		wake_up(3);
		chk(n, lock_cyc + FULL_CYC + 1);
		chk(32'(cur), 6);
		$display("crystal wakes done");
		finish_test();
	end
endmodule : sleep_idle_wake_control_tb_top

/* verilog/siwc_pkg.sv */
// What this block does
// - power-save instruction enters Sleep or Idle only
// - Sleep stops processor, peripheral clocks and oscillator
// - no clock monitor in Sleep; RC runs for watchdog
// - brown-out and low-voltage detector keep running
// - interrupt, reset or watchdog time-out ends Sleep
// - wake restarts pre-Sleep clock or system clock
// - power-on/brown-out wake takes configured oscillator
// - crystal wake waits for start-up timer
// - PLL wake waits lock, then full delays
// - fast clock sources wake after power-on delay
// - kept low-power crystal wakes after power-on delay
// - watchdog in Sleep wakes and sets flag
package siwc_pkg;
	// timing
	localparam int CLK_NS = 100;
	localparam int POR_NS = 10000;
	localparam int LOCK_NS = 20000;
	localparam int POWERUP_TIMER_NS = 100000;
	localparam int TMR_W = 16;
	localparam logic [TMR_W-1:0] POR_CYC = TMR_W'((POR_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] LOCK_CYC = TMR_W'((LOCK_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] POWERUP_TIMER_CYC = TMR_W'((POWERUP_TIMER_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] OST_CYC = 16'h0400;
	localparam logic [TMR_W-1:0] FULL_CYC = POR_CYC + LOCK_CYC + POWERUP_TIMER_CYC;

	// bus map
	localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
	localparam logic [31:0] STAT_ADDR = 32'h0000_0004;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [2:0] {
		OSC_EC = 3'h0,
		OSC_FRC = 3'h1,
		OSC_LOW_POWER_RC_CLOCK = 3'h2,
		OSC_ERC = 3'h3,
		OSC_LP = 3'h4,
		OSC_XT = 3'h5,
		OSC_XT_PLL = 3'h6,
		OSC_PRI = 3'h7
	} siwc_osc_e;

	// gray along run, sleep, ost, lock, delay
	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_SLEEP = 3'h1,
		ST_OST = 3'h3,
		ST_LOCK = 3'h2,
		ST_DLY = 3'h6,
		ST_IDLE = 3'h4
	} siwc_state_e;

	typedef struct packed {
		logic wdt;
		logic por;
		logic bor;
		logic master_clear_pin;
		logic irq;
	} siwc_wake_s;

	typedef struct packed {
		logic [22:0] rsvd;
		logic lp_keep;
		logic clock_fail_monitor_en;
		logic lvd_en;
		logic bor_en;
		logic wdt_en;
		siwc_osc_e new_osc_sel;
		logic clk_switch_en;
	} siwc_ctrl_s;

	typedef struct packed {
		logic [18:0] rsvd;
		siwc_wake_s flags;
		logic rsvd7;
		logic pll_locked;
		siwc_osc_e cur_osc;
		siwc_state_e state;
	} siwc_stat_s;

	typedef struct packed {
		logic cpu_clk_en;
		logic periph_clk_en;
		logic osc_en;
		logic pll_en;
		logic low_power_rc_clock_en;
		logic clock_fail_monitor_on;
		logic bor_on;
		logic lvd_on;
		logic wdt_on;
		logic wdt_reset_req;
	} siwc_clk_s;

	localparam siwc_ctrl_s CTRL_RST = '{default: '0, new_osc_sel: OSC_FRC};

	function automatic siwc_osc_e osc_from_cfg(input logic [2:0] fam, input logic [4:0] pri);
		osc_from_cfg = (fam == OSC_PRI) ? siwc_osc_e'(3'(pri)) : siwc_osc_e'(fam);
	endfunction : osc_from_cfg

	function automatic logic is_crystal(input siwc_osc_e osc);
		is_crystal = (osc == OSC_LP) || (osc == OSC_XT) || (osc == OSC_XT_PLL);
	endfunction : is_crystal
endpackage : siwc_pkg

/* verilog/siwc_timer.sv */
`timescale 1ns/1ps
module siwc_timer
	import siwc_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control
	input wire logic load,
	input wire logic [TMR_W-1:0] load_val,
	// status
	output logic busy,
	output logic done
);
	logic [TMR_W-1:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;

	// done pulses in the last counted cycle, so a load of n ends after n cycles
	assign done = busy_reg && (cnt_reg == TMR_W'(1));
	assign busy = busy_reg;

	always_comb begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		if (load) begin
			cnt_next = load_val;
			busy_next = 1'b1;
		end else if (busy_reg) begin
			cnt_next = cnt_reg - TMR_W'(1);
			busy_next = !done;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
		end
	end
endmodule : siwc_timer

/* verilog/siwc_top.sv */
`timescale 1ns/1ps
module siwc_top
	import siwc_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// processor core
	input wire logic power_save_instruction,
	input wire logic power_save_sleep_sel,
	// wake sources and clock generator status
	input wire siwc_wake_s wake_src,
	input wire logic pll_locked,
	input wire logic [2:0] osc_family_config,
	input wire logic [4:0] primary_osc_config,
	// clock controls
	output siwc_clk_s clk_ctl,
	output siwc_osc_e current_osc_select
);
	// bus group
	logic wr_pend_reg, wr_pend_next;
	logic [31:0] addr_reg, addr_next;
	logic [31:0] rdata_reg, rdata_next;
	siwc_ctrl_s ctrl_reg, ctrl_next;
	siwc_wake_s flags_reg, flags_next;
	siwc_wake_s flag_set, flag_clr;
	logic addr_ok;
	siwc_stat_s stat_view;

	// sequencer group
	siwc_state_e state_reg, state_next;
	siwc_osc_e cur_osc_reg, cur_osc_next, wake_osc;
	logic init_done_reg;
	siwc_clk_s clk_reg, clk_next;
	logic wdt_req;
	logic any_wake;
	logic tmr_load, tmr_done;
	logic [TMR_W-1:0] tmr_val;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;
	assign clk_ctl = clk_reg;
	assign current_osc_select = cur_osc_reg;
	// only whole-word singles are expected; narrower sizes act on the whole word
	assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign any_wake = |wake_src;

	always_comb begin
		wr_pend_next = addr_ok && hwrite;
		addr_next = addr_ok ? haddr : addr_reg;
		ctrl_next = ctrl_reg;
		flag_clr = '0;
		if (wr_pend_reg && addr_reg == CTRL_ADDR) begin
			ctrl_next = siwc_ctrl_s'(hwdata);
			ctrl_next.rsvd = '0;
		end
		if (wr_pend_reg && addr_reg == STAT_ADDR) begin
			flag_clr = siwc_wake_s'(hwdata[12:8]);
		end
		flags_next = (flags_reg & ~flag_clr) | flag_set;
		stat_view = '0;
		stat_view.flags = flags_next;
		stat_view.pll_locked = pll_locked;
		stat_view.cur_osc = cur_osc_reg;
		stat_view.state = state_reg;
		rdata_next = rdata_reg;
		// read values include a write finishing in this same cycle
		if (addr_ok && !hwrite) begin
			if (haddr == CTRL_ADDR) begin
				rdata_next = ctrl_next;
			end else if (haddr == STAT_ADDR) begin
				rdata_next = stat_view;
			end else begin
				rdata_next = '0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= '0;
			rdata_reg <= '0;
			ctrl_reg <= CTRL_RST;
			flags_reg <= '0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			addr_reg <= addr_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			flags_reg <= flags_next;
		end
	end

	siwc_timer u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(tmr_load),
		.load_val(tmr_val),
		.busy(),
		.done(tmr_done)
	);

	always_comb begin
		state_next = state_reg;
		cur_osc_next = cur_osc_reg;
		tmr_load = 1'b0;
		tmr_val = POR_CYC;
		flag_set = '0;
		wdt_req = 1'b0;
		if (wake_src.por || wake_src.bor || !ctrl_reg.clk_switch_en) begin
			wake_osc = osc_from_cfg(osc_family_config, primary_osc_config);
		end else begin
			wake_osc = cur_osc_reg;
		end
		// configuration is caught one edge after reset release
		if (!init_done_reg) begin
			cur_osc_next = osc_from_cfg(osc_family_config, primary_osc_config);
		end
		case (state_reg)
			ST_RUN: begin
				if (init_done_reg && ctrl_reg.clk_switch_en) begin
					cur_osc_next = ctrl_reg.new_osc_sel;
				end
				wdt_req = wake_src.wdt;
				if (power_save_instruction) begin
					state_next = power_save_sleep_sel ? ST_SLEEP : ST_IDLE;
				end
			end
			ST_IDLE: begin
				wdt_req = wake_src.wdt;
				if (any_wake) begin
					flag_set = wake_src;
					state_next = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (any_wake) begin
					flag_set = wake_src;
					cur_osc_next = wake_osc;
					tmr_load = 1'b1;
					if (ctrl_reg.lp_keep && cur_osc_reg == OSC_LP && wake_osc == OSC_LP) begin
						state_next = ST_DLY;
					end else if (!is_crystal(wake_osc)) begin
						state_next = ST_DLY;
					end else begin
						tmr_val = OST_CYC;
						state_next = ST_OST;
					end
				end
			end
			ST_OST: begin
				if (tmr_done) begin
					if (cur_osc_reg == OSC_XT_PLL) begin
						state_next = ST_LOCK;
					end else begin
						tmr_load = 1'b1;
						tmr_val = FULL_CYC;
						state_next = ST_DLY;
					end
				end
			end
			ST_LOCK: begin
				if (pll_locked) begin
					tmr_load = 1'b1;
					tmr_val = FULL_CYC;
					state_next = ST_DLY;
				end
			end
			ST_DLY: begin
				if (tmr_done) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
		clk_next.cpu_clk_en = (state_next == ST_RUN);
		clk_next.periph_clk_en = (state_next == ST_RUN) || (state_next == ST_IDLE);
		// sleep shuts the oscillator unless a low-power crystal is kept
		clk_next.osc_en = (state_next != ST_SLEEP) || (ctrl_reg.lp_keep && cur_osc_next == OSC_LP);
		clk_next.pll_en = (cur_osc_next == OSC_XT_PLL) && (state_next != ST_SLEEP);
		// rc clock stays for the watchdog
		clk_next.low_power_rc_clock_en = ctrl_reg.wdt_en || (cur_osc_next == OSC_LOW_POWER_RC_CLOCK && state_next != ST_SLEEP);
		clk_next.clock_fail_monitor_on = ctrl_reg.clock_fail_monitor_en && clk_next.periph_clk_en;
		clk_next.bor_on = ctrl_reg.bor_en;
		clk_next.lvd_on = ctrl_reg.lvd_en;
		clk_next.wdt_on = ctrl_reg.wdt_en;
		clk_next.wdt_reset_req = wdt_req;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_RUN;
			cur_osc_reg <= OSC_FRC;
			init_done_reg <= 1'b0;
			clk_reg <= '0;
		end else begin
			state_reg <= state_next;
			cur_osc_reg <= cur_osc_next;
			init_done_reg <= 1'b1;
			clk_reg <= clk_next;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	localparam int FAST_WAKE_CYC = int'(POR_CYC) + 1;

	sequence fast_wake_s;
		state_reg == ST_SLEEP && any_wake && !is_crystal(wake_osc);
	endsequence

	sequence crystal_wake_s;
		state_reg == ST_SLEEP && any_wake && is_crystal(wake_osc) && !ctrl_reg.lp_keep;
	endsequence

	power_save_entry_a: assert property (
		state_reg == ST_RUN && power_save_instruction |=>
			state_reg == ($past(power_save_sleep_sel) ? ST_SLEEP : ST_IDLE))
		else $error("power-save entry went to the wrong state");
	sleep_clocks_off_a: assert property (
		state_reg == ST_SLEEP |-> !clk_reg.cpu_clk_en && !clk_reg.periph_clk_en &&
			(clk_reg.osc_en == (ctrl_reg.lp_keep && cur_osc_reg == OSC_LP)))
		else $error("clocks running during sleep");
	sleep_monitors_a: assert property (
		state_reg == ST_SLEEP |-> !clk_reg.clock_fail_monitor_on && (clk_reg.low_power_rc_clock_en == ctrl_reg.wdt_en))
		else $error("monitor or rc clock wrong in sleep");
	detector_keep_a: assert property (
		state_reg == ST_SLEEP && $stable(ctrl_reg) |-> clk_reg.bor_on == ctrl_reg.bor_en &&
			clk_reg.lvd_on == ctrl_reg.lvd_en)
		else $error("detector dropped in sleep");
	sleep_exit_a: assert property (
		state_reg == ST_SLEEP && any_wake |=> state_reg != ST_SLEEP && !clk_reg.cpu_clk_en)
		else $error("wake event did not leave sleep");
	wake_osc_keep_a: assert property (
		state_reg == ST_SLEEP && any_wake && ctrl_reg.clk_switch_en && !wake_src.por && !wake_src.bor
			|=> $stable(cur_osc_reg))
		else $error("pre-sleep clock not restored");
	reset_osc_cfg_a: assert property (
		state_reg == ST_SLEEP && (wake_src.por || wake_src.bor) |=>
			cur_osc_reg == osc_from_cfg($past(osc_family_config), $past(primary_osc_config)))
		else $error("reset wake ignored configuration");
	crystal_hold_a: assert property (
		crystal_wake_s |=> (state_reg == ST_OST && !clk_reg.cpu_clk_en)[*8])
		else $error("crystal clock released before start-up timer");
	pll_hold_a: assert property (
		state_reg == ST_LOCK && !pll_locked |=> state_reg == ST_LOCK && !clk_reg.cpu_clk_en)
		else $error("clock released before pll lock");
	fast_wake_a: assert property (
		fast_wake_s |-> ##FAST_WAKE_CYC state_reg == ST_RUN)
		else $error("fast wake delay not the power-on delay");
	wdt_flag_a: assert property (
		state_reg == ST_SLEEP && wake_src.wdt |=> flags_reg.wdt && !clk_reg.wdt_reset_req)
		else $error("watchdog wake not flagged");
	idle_clocks_a: assert property (
		state_reg == ST_IDLE |-> !clk_reg.cpu_clk_en && clk_reg.periph_clk_en)
		else $error("idle clocks wrong");
endmodule : siwc_top
